/* src/pls_pkg.sv */
// Constants for the link status and slot capability register bank.
// Assumes a single core clock and synchronous active-high reset.
package pls_pkg;
   localparam logic [11:0] PLS_LINK_STAT_OFF = 12'h0d0;
   localparam logic [11:0] PLS_SLOT_CAP_OFF  = 12'h0d4;

   // Link status fields, positions within the dword at the link offset
   localparam int PLS_SPEED_LSB  = 16;
   localparam int PLS_WIDTH_LSB  = 20;
   localparam int PLS_TERR_BIT   = 26;
   localparam int PLS_TRAIN_BIT  = 27;
   localparam int PLS_SCLK_BIT   = 28;
   localparam int PLS_DLACT_BIT  = 29;
   localparam int PLS_BWMS_BIT   = 30;
   localparam int PLS_ABWS_BIT   = 31;

   localparam logic [3:0] PLS_SPEED_2G5 = 4'h1;
   localparam logic [3:0] PLS_SPEED_5G0 = 4'h2;
   localparam logic [3:0] PLS_SPEED_RST = PLS_SPEED_5G0;
   localparam logic [5:0] PLS_WIDTH_RST = 6'h01;
   localparam logic       PLS_TRAIN_RST = 1'b1;
   localparam logic       PLS_SCLK_RST  = 1'b1;

   // Slot capability fields
   localparam int PLS_PRES_LSB   = 0;
   localparam int PLS_SURP_BIT   = 5;
   localparam int PLS_HPCAP_BIT  = 6;
   localparam int PLS_PLV_LSB    = 7;
   localparam int PLS_PLS_LSB    = 15;
   localparam int PLS_PSN_LSB    = 19;

   localparam logic [4:0]  PLS_PRES_RST  = 5'h1f;
   localparam logic        PLS_SURP_RST  = 1'b0;
   localparam logic        PLS_HPCAP_RST = 1'b1;
   localparam logic [7:0]  PLS_PLV_RST   = 8'h19;
   localparam logic [1:0]  PLS_PLS_RST   = 2'h0;
   localparam logic [12:0] PLS_PSN_RST   = 13'h0000;
endpackage

/* src/pls_msg_if.sv */
// Carrier between the register bank and the power limit message generator.
// Assumes both ends sit on the same core clock.
`timescale 1ns/10ps
interface pls_msg_if;
   logic       trig;
   logic [7:0] value;
   logic [1:0] scale;

   modport src (output trig, output value, output scale);
   modport gen (input  trig, input  value, input  scale);
endinterface

/* src/pls_power_msg.sv */
// Set_Slot_Power_Limit message request generator.
// Assumes the message transmitter acknowledges with a one-cycle ack.
`timescale 1ns/10ps
module pls_power_msg
   import pls_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   pls_msg_if.gen          mif,
   input  wire logic       msg_ack,
   output logic            msg_req,
   output logic [7:0]      msg_value,
   output logic [1:0]      msg_scale
);
   logic       req_q;
   logic       req_d;
   logic [7:0] val_q;
   logic [1:0] scl_q;

   // A new write re-arms the request and refreshes the payload
   assign req_d = mif.trig | (req_q & ~msg_ack);

   always_ff @(posedge mclk) begin
      if (rst) begin
         req_q <= 1'b0;
         val_q <= PLS_PLV_RST;
         scl_q <= PLS_PLS_RST;
      end else begin
         req_q <= req_d;
         if (mif.trig) begin
            val_q <= mif.value;
            scl_q <= mif.scale;
         end
      end
   end

   assign msg_req   = req_q;
   assign msg_value = val_q;
   assign msg_scale = scl_q;
endmodule

/* src/pls_regs.sv */
// Link status and slot capability register bank of one switch port.
// Assumes link, training and preload inputs come from logic on mclk.
//
// Notes on behaviour
// - Link speed is a read-only four-bit field, 0001b for 2.5 Gb/s, 0010b for 5.0 Gb/s, reset 0010b.
// - Negotiated width is a read-only six-bit field at bits 25:20 resetting to one lane.
// - Training error at bit 26 is set on a failed training and cleared on a good training to L0.
// - Training in progress at bit 27 is high while training runs, cleared at completion, resets to one.
// - Bit 28 shows use of the connector reference clock, resetting to one.
// - Bit 29 is one while the data link layer is in DL_Active, resetting to zero.
// - Slot capability bits 0 to 4 advertise the five hot-plug elements, each resetting to one.
// - Slot capability bit 6 marks hot-plug capability, resetting to one.
// - Power limit value at bits 14:7 resets to 19h; a write outside a preload requests a power limit message, merged into any request still unacknowledged.
// - Power limit scale at bits 16:15 resets to 00b; a write outside a preload requests a power limit message, merged into any request still unacknowledged.
// - Physical slot number at bits 31:19 is read-only and resets to zero.
// - Clock configuration and slot capability defaults may be replaced by a preload.
// - The slot capability register and message exist only on downstream ports.
`timescale 1ns/10ps
module pls_regs
   import pls_pkg::*;
#(
   parameter bit IS_DOWNSTREAM = 1'b1
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   // Configuration access
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [11:0] cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   output logic             cfg_rvalid,
   // Link layer state
   input  wire logic        train_start,
   input  wire logic        train_done,
   input  wire logic        train_fail,
   input  wire logic [3:0]  neg_speed,
   input  wire logic [5:0]  neg_width,
   input  wire logic        dl_active,
   input  wire logic        bw_mgmt_evt,
   input  wire logic        bw_auto_evt,
   // Default preload
   input  wire logic        pre_load,
   input  wire logic        pre_sclk,
   input  wire logic [31:0] pre_slot_cap,
   // Power limit message
   input  wire logic        msg_ack,
   output logic             msg_req,
   output logic [7:0]       msg_value,
   output logic [1:0]       msg_scale
);
   ////////////////////////////////////////////////////////////////////////////
   logic [3:0]  speed_q;
   logic [5:0]  width_q;
   logic        terr_q;
   logic        train_q;
   logic        sclk_q;
   logic        dlact_q;
   logic        bwms_q;
   logic        abws_q;
   logic [4:0]  pres_q;
   logic        surp_q;
   logic        hpcap_q;
   logic [7:0]  plv_q;
   logic [7:0]  plv_d;
   logic [1:0]  plsc_q;
   logic [1:0]  plsc_d;
   logic [12:0] psn_q;
   logic [31:0] rdata_q;
   logic        rvalid_q;

   pls_msg_if mif ();

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire         hit_link = (cfg_addr[11:2] == PLS_LINK_STAT_OFF[11:2]);
   wire         hit_slot = (cfg_addr[11:2] == PLS_SLOT_CAP_OFF[11:2]) && IS_DOWNSTREAM;
   wire         wr_link  = cfg_wr & hit_link;
   wire         wr_slot  = cfg_wr & hit_slot;
   wire [31:0]  be_mask  = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
   wire [31:0]  wmask    = cfg_wdata & be_mask;
   wire [31:0]  slot_wen = wr_slot ? be_mask : 32'h0000_0000;
   wire         plv_wr   = |slot_wen[PLS_PLV_LSB +: 8];
   wire         plsc_wr  = |slot_wen[PLS_PLS_LSB +: 2];
   wire         bwms_clr = wr_link & wmask[PLS_BWMS_BIT];
   wire         abws_clr = wr_link & wmask[PLS_ABWS_BIT];

   // Byte-wise merge of the writable power limit fields
   assign plv_d  = (plv_q & ~slot_wen[PLS_PLV_LSB +: 8])
                 | (cfg_wdata[PLS_PLV_LSB +: 8] & slot_wen[PLS_PLV_LSB +: 8]);
   assign plsc_d = (plsc_q & ~slot_wen[PLS_PLS_LSB +: 2])
                 | (cfg_wdata[PLS_PLS_LSB +: 2] & slot_wen[PLS_PLS_LSB +: 2]);

   wire [31:0]  link_word = {abws_q, bwms_q, dlact_q, sclk_q, train_q, terr_q,
                             width_q, speed_q, 16'h0000};
   wire [31:0]  slot_word = {psn_q, 2'h0, plsc_q, plv_q, hpcap_q, surp_q, pres_q};
   wire [31:0]  rd_mux    = hit_link ? link_word :
                            hit_slot ? slot_word : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Link status
   always_ff @(posedge mclk) begin
      if (rst) begin
         speed_q <= PLS_SPEED_RST;
         width_q <= PLS_WIDTH_RST;
         terr_q  <= 1'b0;
         train_q <= PLS_TRAIN_RST;
         dlact_q <= 1'b0;
         bwms_q  <= 1'b0;
         abws_q  <= 1'b0;
      end else begin
         if (train_done) begin
            speed_q <= neg_speed;
            width_q <= neg_width;
         end
         if (train_fail) begin
            terr_q <= 1'b1;
         end else if (train_done) begin
            terr_q <= 1'b0;
         end
         if (train_start) begin
            train_q <= 1'b1;
         end else if (train_done | train_fail) begin
            train_q <= 1'b0;
         end
         dlact_q <= dl_active;
         // Event wins over a clear in the same cycle
         bwms_q  <= bw_mgmt_evt | (bwms_q & ~bwms_clr);
         abws_q  <= bw_auto_evt | (abws_q & ~abws_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock configuration and slot capability
   always_ff @(posedge mclk) begin
      if (rst) begin
         sclk_q  <= PLS_SCLK_RST;
         pres_q  <= IS_DOWNSTREAM ? PLS_PRES_RST : 5'h00;
         surp_q  <= PLS_SURP_RST;
         hpcap_q <= IS_DOWNSTREAM ? PLS_HPCAP_RST : 1'b0;
         plv_q   <= IS_DOWNSTREAM ? PLS_PLV_RST : 8'h00;
         plsc_q  <= PLS_PLS_RST;
         psn_q   <= PLS_PSN_RST;
      end else if (pre_load) begin
         sclk_q <= pre_sclk;
         if (IS_DOWNSTREAM) begin
            pres_q  <= pre_slot_cap[PLS_PRES_LSB +: 5];
            surp_q  <= pre_slot_cap[PLS_SURP_BIT];
            hpcap_q <= pre_slot_cap[PLS_HPCAP_BIT];
            plv_q   <= pre_slot_cap[PLS_PLV_LSB +: 8];
            plsc_q  <= pre_slot_cap[PLS_PLS_LSB +: 2];
            psn_q   <= pre_slot_cap[PLS_PSN_LSB +: 13];
         end
      end else begin
         plv_q  <= plv_d;
         plsc_q <= plsc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read answer one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_q  <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= cfg_rd;
         rdata_q  <= cfg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign cfg_rdata  = rdata_q;
   assign cfg_rvalid = rvalid_q;

   ////////////////////////////////////////////////////////////////////////////
   // Power limit message; a preload does not send one
   assign mif.trig  = (plv_wr | plsc_wr) & ~pre_load;
   assign mif.value = plv_d;
   assign mif.scale = plsc_d;

   pls_power_msg u_msg (
      .mclk      (mclk),
      .rst       (rst),
      .mif       (mif),
      .msg_ack   (msg_ack),
      .msg_req   (msg_req),
      .msg_value (msg_value),
      .msg_scale (msg_scale)
   );
endmodule

/* sim/pls_xmit_model.sv */
// Model of the power limit message transmitter.
// Assumes msg_req is a level held until acknowledged.
`timescale 1ns/10ps
module pls_xmit_model (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [3:0] lat,
   input  wire logic       msg_req,
   input  wire logic [7:0] msg_value,
   input  wire logic [1:0] msg_scale,
   output logic            msg_ack,
   output logic [9:0]      got,
   output int              n_msg
);
   logic [3:0] cnt_q;
   always_ff @(posedge mclk) begin
      msg_ack <= 1'b0;
      if (rst) begin
         cnt_q <= '0;
         n_msg <= 0;
         got <= '0;
      end else if (msg_req && !msg_ack) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q >= lat) begin
            msg_ack <= 1'b1;
            got <= {msg_value, msg_scale};
            n_msg <= n_msg + 1;
            cnt_q <= '0;
         end
      end
   end
endmodule

/* sim/pls_regs_assertions.sv */
// Checker for the link status and slot capability bank.
// Assumes binding onto pls_regs with all inputs on mclk.
`timescale 1ns/10ps
module pls_regs_chk
   import pls_pkg::*;
#(
   parameter bit IS_DOWNSTREAM = 1'b1
)(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        cfg_wr,
   input wire logic        cfg_rd,
   input wire logic [11:0] cfg_addr,
   input wire logic [3:0]  cfg_be,
   input wire logic [31:0] cfg_rdata,
   input wire logic        train_start,
   input wire logic        train_done,
   input wire logic        train_fail,
   input wire logic [3:0]  neg_speed,
   input wire logic [5:0]  neg_width,
   input wire logic        dl_active,
   input wire logic        bw_mgmt_evt,
   input wire logic        pre_load,
   input wire logic        msg_ack,
   input wire logic        msg_req,
   input wire logic [7:0]  msg_value
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire rd_l = cfg_rd && cfg_addr[11:2] == PLS_LINK_STAT_OFF[11:2];
   wire wr_s = cfg_wr && !pre_load && IS_DOWNSTREAM
               && cfg_addr[11:2] == PLS_SLOT_CAP_OFF[11:2];
   wire quiet = !(train_start || train_done || train_fail || cfg_wr);
   sequence s_upd(ev);
      ev ##1 quiet ##1 rd_l;
   endsequence
   a_speed_load: assert property (s_upd(train_done) |=>
      cfg_rdata[19:16] == $past(neg_speed, 3)) else $error("speed field wrong");
   a_width_load: assert property (s_upd(train_done) |=>
      cfg_rdata[25:20] == $past(neg_width, 3)) else $error("width field wrong");
   a_err_set: assert property (s_upd(train_fail && !train_start) |=>
      cfg_rdata[26] && !cfg_rdata[27]) else $error("training error flag wrong");
   a_train_set: assert property (s_upd(train_start && !train_done && !train_fail) |=>
      cfg_rdata[27]) else $error("training flag not set");
   a_dl_mirror: assert property (rd_l && !$past(rst) |=>
      cfg_rdata[29] == $past(dl_active, 2)) else $error("link active bit wrong");
   a_bw_set: assert property (s_upd(bw_mgmt_evt) |=> cfg_rdata[30])
      else $error("bandwidth status not set");
   a_msg_plv: assert property (wr_s && |cfg_be[1:0] |=> msg_req)
      else $error("no message after value write");
   a_msg_scale: assert property (wr_s && |cfg_be[2:1] |=> msg_req)
      else $error("no message after scale write");
   a_msg_hold: assert property (msg_req && !msg_ack |=> msg_req)
      else $error("message dropped before ack");
   a_msg_drop: assert property (msg_req && msg_ack && !cfg_wr |=> !msg_req)
      else $error("message held after ack");
   a_pay_keep: assert property (msg_req && !cfg_wr && !pre_load |=> $stable(msg_value))
      else $error("payload changed while pending");
   c_slow_ack: cover property ((msg_req && !msg_ack) [*3]);
   c_fail_rd: cover property (s_upd(train_fail));
   c_ack: cover property (msg_req && msg_ack);
endmodule
bind pls_regs pls_regs_chk #(.IS_DOWNSTREAM(IS_DOWNSTREAM)) u_pls_regs_chk (.mclk, .rst,
   .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
   .cfg_rdata, .train_start, .train_done, .train_fail, .neg_speed, .neg_width, .dl_active,
   .bw_mgmt_evt, .pre_load, .msg_ack, .msg_req, .msg_value);

/* sim/pls_regs_tb.sv */
// Bench for the link status and slot capability bank.
// Assumes pls_xmit_model answers the power limit messages.
`timescale 1ns/10ps
module pls_regs_tb
   import pls_pkg::*;
();
   localparam logic [11:0] LK = PLS_LINK_STAT_OFF;
   localparam logic [11:0] SC = PLS_SLOT_CAP_OFF;
   logic        mclk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
   logic [11:0] cfg_addr = '0;
   logic [3:0]  cfg_be = '0, neg_speed = 4'h2, lat = '0;
   logic [31:0] cfg_wdata = '0, pre_slot_cap = '0, cfg_rdata;
   logic [4:0]  ev = '0;
   logic [5:0]  neg_width = 6'h01;
   logic        dl_active = 1'b0, pre_load = 1'b0, pre_sclk = 1'b1;
   logic        cfg_rvalid, msg_ack, msg_req;
   logic [7:0]  msg_value;
   logic [1:0]  msg_scale;
   logic [9:0]  got;
   int          n_msg, fails = 0, n_tests = 0, cyc = 0;
   logic [31:0] up_rdata;
   logic        up_rvalid, up_req;
   pls_regs u_pls_regs (.mclk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
      .cfg_rdata, .cfg_rvalid, .train_start(ev[4]), .train_done(ev[3]), .train_fail(ev[2]),
      .neg_speed, .neg_width, .dl_active, .bw_mgmt_evt(ev[1]), .bw_auto_evt(ev[0]),
      .pre_load, .pre_sclk, .pre_slot_cap, .msg_ack, .msg_req, .msg_value, .msg_scale);
   pls_xmit_model u_pls_xmit_model (.mclk, .rst, .lat, .msg_req, .msg_value, .msg_scale,
      .msg_ack, .got, .n_msg);
   // Upstream port on the same bus: slot caps refused, never a message
   pls_regs #(.IS_DOWNSTREAM(1'b0)) u_pls_regs_up (.mclk, .rst, .cfg_wr, .cfg_rd, .cfg_addr,
      .cfg_be, .cfg_wdata, .cfg_rdata(up_rdata), .cfg_rvalid(up_rvalid), .train_start(ev[4]),
      .train_done(ev[3]), .train_fail(ev[2]), .neg_speed, .neg_width, .dl_active,
      .bw_mgmt_evt(ev[1]), .bw_auto_evt(ev[0]), .pre_load, .pre_sclk, .pre_slot_cap,
      .msg_ack(1'b0), .msg_req(up_req), .msg_value(), .msg_scale());
   always #50 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge mclk);
      {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, b, d};
      @(posedge mclk);
      cfg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge mclk);
      {cfg_rd, cfg_addr} <= {1'b1, a};
      @(posedge mclk);
      cfg_rd <= 1'b0;
      #1;
      chk(cfg_rvalid === 1'b1 ? cfg_rdata : 32'hx, e);
   endtask
   task automatic up_chk(input logic [31:0] e);
      chk(up_rvalid === 1'b1 ? up_rdata : 32'hx, e);
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= '0;
   endtask
   task automatic wait_msg(input int n);
      repeat (20) if (n_msg < n) @(posedge mclk);
      chk(n_msg, n);
   endtask
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(LK, 32'h1812_0000);
      up_chk(32'h1812_0000);
      rd(SC, 32'h0000_0cdf);
      up_chk(32'h0);
      rd(12'h0e0, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_train;
      pulse(5'h04);
      rd(LK, 32'h1412_0000);
      pulse(5'h10);
      rd(LK, 32'h1c12_0000);
      @(posedge mclk);
      {neg_speed, neg_width, dl_active} <= {4'h1, 6'h04, 1'b1};
      pulse(5'h08);
      rd(LK, 32'h3041_0000);
      $display("train test done");
   endtask
   task automatic t_bw;
      pulse(5'h03);
      rd(LK, 32'hf041_0000);
      wr(LK, 4'h8, 32'h4fff_ffff);
      rd(LK, 32'hb041_0000);
      wr(LK, 4'h7, 32'hffff_ffff);
      rd(LK, 32'hb041_0000);
      wr(LK, 4'h8, 32'h8000_0000);
      dl_active <= 1'b0;
      rd(LK, 32'h1041_0000);
      $display("bandwidth test done");
   endtask
   task automatic t_msg;
      wr(SC, 4'hf, 32'hffff_ffff);
      rd(SC, 32'h0001_ffdf);
      up_chk(32'h0);
      chk({31'h0, up_req}, 32'h0);
      wait_msg(1);
      chk({22'h0, got}, 32'h3ff);
      lat <= 4'h5;
      wr(SC, 4'h4, 32'h0);
      rd(SC, 32'h0000_ffdf);
      chk({31'h0, msg_req}, 32'h1);
      wait_msg(2);
      chk({22'h0, got}, 32'h3fd);
      $display("message test done");
   endtask
   task automatic t_pre;
      @(posedge mclk);
      {pre_load, pre_sclk, pre_slot_cap} <= {1'b1, 1'b0, 32'h8008_4020};
      @(posedge mclk);
      pre_load <= 1'b0;
      rd(LK, 32'h0041_0000);
      up_chk(32'h0041_0000);
      rd(SC, 32'h8008_4020);
      up_chk(32'h0);
      chk(n_msg, 2);
      $display("preload test done");
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_train;
      t_bw;
      t_msg;
      t_pre;
      complete_run;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fails++;
         complete_run;
      end
   end
endmodule
